// ==== logic/can_rxbuf_pkg.sv ====
// Shared constants for the dedicated receive buffer control block
package can_rxbuf_pkg;
	// Bus and register widths
	localparam int DATA_W = 32;
	localparam int ADDR_W = 5;
	localparam int REG_W = 8;
	localparam int HIT_W = 5;
	localparam int MODE_W = 2;
	localparam int NBUF = 2;

	// Byte offsets of the word-aligned registers
	localparam logic [ADDR_W-1:0] OFS_BUF0 = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_BUF1 = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_MASK = 5'h0c;
	localparam logic [ADDR_W-1:0] OFS_MODE = 5'h10;

	// Control register field positions
	localparam int BIT_FULL = 7;
	localparam int BIT_RX_ACCEPT_MODE_HI = 6;
	localparam int BIT_RX_ACCEPT_MODE_LO = 5;
	localparam int BIT_DBEN = 2;

	// Operating modes: legacy, enhanced 1, enhanced 2, reserved
	typedef enum logic [MODE_W-1:0] {MODE_LEGACY, MODE_ENH1, MODE_ENH2, MODE_RSVD} op_mode_t;

	// Legacy two-bit receive filter modes
	localparam logic [1:0] RXM_ALL = 2'h3;
	localparam logic [1:0] RXM_EXT = 2'h2;
	localparam logic [1:0] RXM_STD = 2'h1;
	localparam logic [1:0] RXM_FILT = 2'h0;

	// Legacy routing: filters 0 and 1 feed buffer 0, filters 2 up feed buffer 1
	localparam logic [HIT_W-1:0] LEG_BUF1_HIT = 5'h02;
	localparam logic [HIT_W-1:0] HIT_NONE = 5'h00;

	// Interrupt status layout
	localparam int IRQ_W = 3;
	localparam int IRQ_RX0 = 0;
	localparam int IRQ_RX1 = 1;
	localparam int IRQ_LOST = 2;

	// Reset values
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [HIT_W-1:0] HIT_RST = 5'h00;
	localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
	localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;
endpackage

// ==== logic/can_rx_accept.sv ====
// Acceptance decision of one receive buffer from its mode bits
`timescale 1ns/1ps
module can_rx_accept (
	input wire logic i_legacy,
	input wire logic [1:0] i_rxm,
	input wire logic i_msg_error,
	input wire logic i_msg_ext,
	input wire logic i_filter_match,
	input wire logic i_filter_ext_sel,
	output logic o_accept
);
	// Filter outcomes for each legacy mode
	wire valid_match = !i_msg_error && i_filter_match;
	wire leg_filt = valid_match && (i_msg_ext == i_filter_ext_sel);
	wire leg_ext = valid_match && i_msg_ext;
	wire leg_std = valid_match && !i_msg_ext;
	logic leg_accept;

	// Legacy: accept-all ignores filters and even lets erroneous frames
	always_comb begin
		case (i_rxm)
			can_rxbuf_pkg::RXM_ALL: leg_accept = 1'b1;
			can_rxbuf_pkg::RXM_EXT: leg_accept = leg_ext;
			can_rxbuf_pkg::RXM_STD: leg_accept = leg_std;
			can_rxbuf_pkg::RXM_FILT: leg_accept = leg_filt;
			default: leg_accept = 1'b0;
		endcase
	end

	// Enhanced: only the upper mode bit counts, filters bypassed when set
	wire enh_accept = i_rxm[1] || valid_match;

	assign o_accept = i_legacy ? leg_accept : enh_accept;
endmodule // can_rx_accept

// ==== logic/irq_status_bank.sv ====
// Sticky interrupt status with write-one-to-clear, mask and level output
`timescale 1ns/1ps
module irq_status_bank (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic [can_rxbuf_pkg::IRQ_W-1:0] i_set,
	input wire logic i_clr_we,
	input wire logic i_mask_we,
	input wire logic [can_rxbuf_pkg::IRQ_W-1:0] i_wdata,
	output logic [can_rxbuf_pkg::IRQ_W-1:0] o_status,
	output logic [can_rxbuf_pkg::IRQ_W-1:0] o_mask,
	output logic o_irq
);
	logic [can_rxbuf_pkg::IRQ_W-1:0] next_status;
	logic [can_rxbuf_pkg::IRQ_W-1:0] next_mask;

	// A set arriving with its clear wins, so no event is dropped
	genvar g;
	generate
		for (g = 0; g < can_rxbuf_pkg::IRQ_W; g++) begin : g_bit
			assign next_status[g] = i_set[g] || (o_status[g] && !(i_clr_we && i_wdata[g]));
		end
	endgenerate
	assign next_mask = i_mask_we ? i_wdata : o_mask;

	// Interrupt follows next values so it tracks status without extra lag
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_status <= can_rxbuf_pkg::IRQ_RST;
			o_mask <= can_rxbuf_pkg::IRQ_RST;
			o_irq <= 1'b0;
		end else if (i_ce) begin
			o_status <= next_status;
			o_mask <= next_mask;
			o_irq <= |(next_status & next_mask);
		end
	end
endmodule // irq_status_bank

// ==== logic/can_rxbuf_ctrl.sv ====
// Control and status of the two dedicated CAN receive buffers
//
// Notes on behaviour
// - Full flag in bit 7 is set on store; software may only clear it.
// - A buffer whose full flag is set never takes a new message.
// - Buffer 0 interrupt flag is set again while its full flag stays set.
// - Legacy mode 11 all, 10 extended, 01 standard, 00 per filter select.
// - Enhanced bit 6 set accepts everything; clear needs a valid filter match.
// - Remote request flag reads at bit 3 legacy, bit 5 enhanced.
// - Legacy double buffering moves a buffer 0 overflow into buffer 1.
// - Legacy buffer 0 bit 1 is a read-only copy of the double-buffer enable.
// - Legacy buffer 0 bit 0 tells whether filter 1 or filter 0 matched.
// - Legacy buffer 1 bits 2..0 hold the matching filter code.
// - Enhanced bits 4..0 of each buffer hold the five-bit filter index.
// - Legacy bit 4 reads zero; hit and remote fields are read-only.
//
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module can_rxbuf_ctrl (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic [can_rxbuf_pkg::ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [can_rxbuf_pkg::DATA_W-1:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [can_rxbuf_pkg::DATA_W-1:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_msg_valid,
	input wire logic i_msg_error,
	input wire logic i_msg_ext,
	input wire logic i_msg_rtr,
	input wire logic i_filter_match,
	input wire logic [can_rxbuf_pkg::HIT_W-1:0] i_filter_hit,
	input wire logic i_filter_ext_sel,
	input wire logic i_enh_to_buf1,
	output logic o_buf0_full,
	output logic o_buf1_full,
	output logic o_msg_lost,
	output logic o_irq
);
	////////////////////////////////////////////////////////////////////////////
	// State

	logic [can_rxbuf_pkg::NBUF-1:0] full;
	logic [can_rxbuf_pkg::NBUF-1:0] rx_accept_mode_hi;
	logic [can_rxbuf_pkg::NBUF-1:0] rx_accept_mode_lo;
	logic [can_rxbuf_pkg::NBUF-1:0] rtr;
	logic [can_rxbuf_pkg::NBUF-1:0][can_rxbuf_pkg::HIT_W-1:0] hit;
	logic dben;
	can_rxbuf_pkg::op_mode_t op_mode;
	logic [can_rxbuf_pkg::IRQ_W-1:0] irq_status;
	logic [can_rxbuf_pkg::IRQ_W-1:0] irq_mask;
	logic [can_rxbuf_pkg::NBUF-1:0] accept;
	logic [can_rxbuf_pkg::NBUF-1:0] store;
	logic [can_rxbuf_pkg::NBUF-1:0] wr_buf;
	logic [can_rxbuf_pkg::DATA_W-1:0] rd_word;

	////////////////////////////////////////////////////////////////////////////
	// Bus decode

	// Registers live in the low byte lane; writes without it are ignored
	wire legacy = (op_mode == can_rxbuf_pkg::MODE_LEGACY);
	wire bus_req = i_avs_read || i_avs_write;
	wire bus_wr = i_ce && i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
	wire sel_buf0 = (i_avs_address == can_rxbuf_pkg::OFS_BUF0);
	wire sel_buf1 = (i_avs_address == can_rxbuf_pkg::OFS_BUF1);
	wire sel_stat = (i_avs_address == can_rxbuf_pkg::OFS_STATUS);
	wire sel_mask = (i_avs_address == can_rxbuf_pkg::OFS_MASK);
	wire sel_mode = (i_avs_address == can_rxbuf_pkg::OFS_MODE);
	wire [can_rxbuf_pkg::REG_W-1:0] wbyte = i_avs_writedata[can_rxbuf_pkg::REG_W-1:0];
	assign wr_buf[0] = bus_wr && sel_buf0;
	assign wr_buf[1] = bus_wr && sel_buf1;

	////////////////////////////////////////////////////////////////////////////
	// Message routing and acceptance

	// Legacy sends filters 2 and up to buffer 1; enhanced takes the pointer given
	wire leg_tgt1 = i_filter_match && (i_filter_hit >= can_rxbuf_pkg::LEG_BUF1_HIT);
	wire tgt1 = legacy ? leg_tgt1 : i_enh_to_buf1;
	wire msg_take = i_msg_valid && i_ce;
	wire [can_rxbuf_pkg::HIT_W-1:0] store_hit = i_filter_match ? i_filter_hit : can_rxbuf_pkg::HIT_NONE;

	// One decider per buffer, each using that buffer's own mode bits
	genvar b;
	generate
		for (b = 0; b < can_rxbuf_pkg::NBUF; b++) begin : g_acc
			can_rx_accept u_accept (
				.i_legacy(legacy),
				.i_rxm({rx_accept_mode_hi[b], rx_accept_mode_lo[b]}),
				.i_msg_error(i_msg_error),
				.i_msg_ext(i_msg_ext),
				.i_filter_match(i_filter_match),
				.i_filter_ext_sel(i_filter_ext_sel),
				.o_accept(accept[b])
			);
		end
	endgenerate

	// An occupied buffer is skipped; overflow may spill into buffer 1
	wire want0 = msg_take && !tgt1 && accept[0];
	wire want1 = msg_take && tgt1 && accept[1];
	wire redirect = want0 && full[0] && legacy && dben && !full[1];
	assign store[0] = want0 && !full[0];
	assign store[1] = (want1 && !full[1]) || redirect;
	wire lost = (want0 || want1) && !store[0] && !store[1];

	////////////////////////////////////////////////////////////////////////////
	// Per-buffer control bits

	generate
		for (b = 0; b < can_rxbuf_pkg::NBUF; b++) begin : g_buf
			// Software writing zero clears full, but a store in that cycle wins
			wire clr_full = wr_buf[b] && !wbyte[can_rxbuf_pkg::BIT_FULL];
			wire next_full = store[b] || (full[b] && !clr_full);
			wire next_rx_accept_mode_hi = wr_buf[b] ? wbyte[can_rxbuf_pkg::BIT_RX_ACCEPT_MODE_HI] : rx_accept_mode_hi[b];
			// Low mode bit is a remote flag in enhanced modes, so not writable there
			wire next_rx_accept_mode_lo = (wr_buf[b] && legacy) ? wbyte[can_rxbuf_pkg::BIT_RX_ACCEPT_MODE_LO] : rx_accept_mode_lo[b];
			// Remote flag and hit land with the full flag; bus writes never touch them
			wire next_rtr = store[b] ? i_msg_rtr : rtr[b];
			wire [can_rxbuf_pkg::HIT_W-1:0] next_hit = store[b] ? store_hit : hit[b];

			always_ff @(posedge i_mclk) begin
				if (!i_rst_n) begin
					full[b] <= 1'b0;
					rx_accept_mode_hi[b] <= 1'b0;
					rx_accept_mode_lo[b] <= 1'b0;
					rtr[b] <= 1'b0;
					hit[b] <= can_rxbuf_pkg::HIT_RST;
				end else if (i_ce) begin
					full[b] <= next_full;
					rx_accept_mode_hi[b] <= next_rx_accept_mode_hi;
					rx_accept_mode_lo[b] <= next_rx_accept_mode_lo;
					rtr[b] <= next_rtr;
					hit[b] <= next_hit;
				end
			end
		end
	endgenerate

	// Double-buffer enable and operating mode
	wire next_dben = (wr_buf[0] && legacy) ? wbyte[can_rxbuf_pkg::BIT_DBEN] : dben;
	wire mode_we = bus_wr && sel_mode;
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			dben <= 1'b0;
			op_mode <= can_rxbuf_pkg::MODE_LEGACY;
		end else if (i_ce) begin
			dben <= next_dben;
			if (mode_we) begin
				op_mode <= can_rxbuf_pkg::op_mode_t'(wbyte[can_rxbuf_pkg::MODE_W-1:0]);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupts

	// Buffer 0 flag is re-armed every cycle its buffer stays full
	wire [can_rxbuf_pkg::IRQ_W-1:0] irq_set = {lost, store[1], store[0] || full[0]};
	irq_status_bank u_irq (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_set(irq_set),
		.i_clr_we(bus_wr && sel_stat),
		.i_mask_we(bus_wr && sel_mask),
		.i_wdata(wbyte[can_rxbuf_pkg::IRQ_W-1:0]),
		.o_status(irq_status),
		.o_mask(irq_mask),
		.o_irq(o_irq)
	);

	////////////////////////////////////////////////////////////////////////////
	// Read-back layouts

	// Legacy buffer 0: bit 4 zero, bit 1 mirrors the enable, bit 0 filter 1/0
	wire [can_rxbuf_pkg::REG_W-1:0] rb0_leg = {full[0], rx_accept_mode_hi[0], rx_accept_mode_lo[0], 1'b0,
		rtr[0], dben, dben, hit[0][0]};
	// Legacy buffer 1: three-bit filter code
	wire [can_rxbuf_pkg::REG_W-1:0] rb1_leg = {full[1], rx_accept_mode_hi[1], rx_accept_mode_lo[1], 1'b0,
		rtr[1], hit[1][2:0]};
	// Enhanced: remote flag at bit 5, five-bit hit index below it
	wire [can_rxbuf_pkg::REG_W-1:0] rb0_enh = {full[0], rx_accept_mode_hi[0], rtr[0], hit[0]};
	wire [can_rxbuf_pkg::REG_W-1:0] rb1_enh = {full[1], rx_accept_mode_hi[1], rtr[1], hit[1]};
	wire [can_rxbuf_pkg::REG_W-1:0] rb0 = legacy ? rb0_leg : rb0_enh;
	wire [can_rxbuf_pkg::REG_W-1:0] rb1 = legacy ? rb1_leg : rb1_enh;
	localparam int PAD_REG = can_rxbuf_pkg::DATA_W - can_rxbuf_pkg::REG_W;
	localparam int PAD_IRQ = can_rxbuf_pkg::DATA_W - can_rxbuf_pkg::IRQ_W;
	localparam int PAD_MODE = can_rxbuf_pkg::DATA_W - can_rxbuf_pkg::MODE_W;

	// Unmapped offsets read as zero and swallow writes
	always_comb begin
		case (1'b1)
			sel_buf0: rd_word = {{PAD_REG{1'b0}}, rb0};
			sel_buf1: rd_word = {{PAD_REG{1'b0}}, rb1};
			sel_stat: rd_word = {{PAD_IRQ{1'b0}}, irq_status};
			sel_mask: rd_word = {{PAD_IRQ{1'b0}}, irq_mask};
			sel_mode: rd_word = {{PAD_MODE{1'b0}}, op_mode};
			default: rd_word = can_rxbuf_pkg::RDATA_RST;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Avalon slave timing and outputs

	// Every access waits exactly one cycle; read data are captured on the
	// edge that drops waitrequest, so they are stable when the master samples
	wire next_wait = !(bus_req && o_avs_waitrequest);
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata <= can_rxbuf_pkg::RDATA_RST;
			o_msg_lost <= 1'b0;
		end else if (i_ce) begin
			o_avs_waitrequest <= next_wait;
			if (i_avs_read && o_avs_waitrequest) begin
				o_avs_readdata <= rd_word;
			end
			o_msg_lost <= lost; // One-cycle pulse per dropped message
		end
	end
	assign o_buf0_full = full[0];
	assign o_buf1_full = full[1];

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);

	AST_FULL_SET: assert property (
		store[0] |=> full[0] && irq_status[can_rxbuf_pkg::IRQ_RX0])
		else $error("buffer 0 full flag not set after store");

	AST_FULL_ONLY_BY_STORE: assert property (
		$rose(full[1]) |-> $past(store[1]))
		else $error("buffer 1 full flag rose without a store");

	AST_NO_LOAD_WHEN_FULL: assert property (
		full[0] && msg_take |=> $stable(hit[0]) && $stable(rtr[0]))
		else $error("occupied buffer 0 was overwritten");

	AST_IRQ0_REARM: assert property (
		full[0] && i_ce |=> irq_status[can_rxbuf_pkg::IRQ_RX0])
		else $error("buffer 0 interrupt flag dropped while full");

	AST_LEGACY_ALL: assert property (
		msg_take && legacy && !tgt1 && !full[0] && {rx_accept_mode_hi[0], rx_accept_mode_lo[0]} == can_rxbuf_pkg::RXM_ALL
		|=> full[0])
		else $error("legacy accept-all mode refused a message");

	AST_LEGACY_STD: assert property (
		legacy && {rx_accept_mode_hi[0], rx_accept_mode_lo[0]} == can_rxbuf_pkg::RXM_STD && i_msg_ext |-> !accept[0])
		else $error("standard-only mode accepted an extended frame");

	AST_ENH_FILTER: assert property (
		!legacy && !rx_accept_mode_hi[1] && (!i_filter_match || i_msg_error) |-> !accept[1])
		else $error("enhanced filtered mode accepted a non-matching frame");

	AST_RTR_CAPTURE: assert property (
		store[0] |=> rtr[0] == $past(i_msg_rtr))
		else $error("remote flag not captured with the message");

	AST_DOUBLE_BUFFER: assert property (
		redirect |=> full[1] && hit[1] == $past(store_hit) && $stable(hit[0]))
		else $error("buffer 0 overflow not moved into buffer 1");

	AST_NO_REDIRECT: assert property (
		want0 && full[0] && !dben |-> !store[1])
		else $error("overflow redirected with double buffering off");

	AST_JUMP_COPY: assert property (
		i_ce && i_avs_read && o_avs_waitrequest && sel_buf0 && legacy
		|=> o_avs_readdata[1] == o_avs_readdata[2] && !o_avs_readdata[4] && !o_avs_waitrequest)
		else $error("legacy buffer 0 read-back layout wrong");

	AST_HIT0_LEGACY: assert property (
		store[0] && legacy |=> hit[0][0] == $past(store_hit[0]))
		else $error("legacy filter hit bit not captured");

	AST_HIT1_CODE: assert property (
		store[1] |=> full[1] && hit[1] == $past(store_hit))
		else $error("buffer 1 hit index not captured with full flag");

	AST_WAIT_ONE: assert property (
		i_ce && bus_req && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("slave did not answer after one wait cycle");

	// Flag and software-side checks: clears, lost reporting, interrupt level, read-only fields and read-back layouts
	AST_FULL_CLEAR: assert property (
		wr_buf[1] && !wbyte[can_rxbuf_pkg::BIT_FULL] && !store[1] |=> !full[1])
		else $error("buffer 1 full flag not cleared by software");

	AST_FULL_STICKY: assert property (
		full[0] && !wr_buf[0] |=> full[0])
		else $error("buffer 0 full flag dropped without a clear");

	AST_STORE_ONLY_EMPTY: assert property (
		(store & full) == '0)
		else $error("message stored into an occupied buffer");

	AST_REARM_AFTER_CLEAR: assert property (
		bus_wr && sel_stat && wbyte[can_rxbuf_pkg::IRQ_RX0] && full[0] |=> irq_status[can_rxbuf_pkg::IRQ_RX0])
		else $error("buffer 0 interrupt flag stayed clear while full");

	AST_LOST_PULSE: assert property (
		i_ce |=> o_msg_lost == $past(lost))
		else $error("lost pulse does not follow the dropped message");

	AST_LOST_STATUS: assert property (
		lost |=> irq_status[can_rxbuf_pkg::IRQ_LOST])
		else $error("dropped message did not set its status bit");

	AST_IRQ_LEVEL: assert property (
		o_irq == |(irq_status & irq_mask))
		else $error("interrupt level does not match masked status");

	AST_UNMAPPED_ZERO: assert property (
		i_ce && i_avs_read && o_avs_waitrequest && !(sel_buf0 || sel_buf1 || sel_stat || sel_mask || sel_mode)
		|=> o_avs_readdata == can_rxbuf_pkg::RDATA_RST)
		else $error("unmapped offset did not read as zero");

	AST_BUF1_BIT4: assert property (
		i_ce && i_avs_read && o_avs_waitrequest && sel_buf1 && legacy |=> !o_avs_readdata[4])
		else $error("legacy buffer 1 bit 4 not read as zero");

	// Remote flag shares the position of the legacy low mode bit
	AST_ENH_RTR_BIT5: assert property (
		i_ce && i_avs_read && o_avs_waitrequest && sel_buf0 && !legacy
		|=> o_avs_readdata[can_rxbuf_pkg::BIT_RX_ACCEPT_MODE_LO] == $past(rtr[0]))
		else $error("enhanced remote flag not at its read-back position");

	AST_FIELDS_READ_ONLY: assert property (
		wr_buf[0] && !store[0] |=> $stable(hit[0]) && $stable(rtr[0]))
		else $error("bus write changed a read-only field");

	AST_DBEN_LEGACY_ONLY: assert property (
		wr_buf[0] && !legacy |=> $stable(dben))
		else $error("double-buffer enable written outside legacy mode");

	COV_REDIRECT: cover property (redirect);
	COV_LOST: cover property (lost);
	COV_REARM: cover property (full[0] ##1 bus_wr && sel_stat ##1 irq_status[can_rxbuf_pkg::IRQ_RX0]);
	COV_ENH_STORE: cover property (!legacy && store[1]);
	COV_FULL_CLEAR: cover property (wr_buf[0] && !wbyte[can_rxbuf_pkg::BIT_FULL] && full[0]);
endmodule // can_rxbuf_ctrl

// ==== bench/can_node_model.sv ====
// Behavioural model of the far-side receive path that hands over finished frames
`timescale 1ns/1ps
module can_node_model (
	input wire logic i_mclk,
	output logic o_valid,
	output logic o_error,
	output logic o_ext,
	output logic o_rtr,
	output logic o_match,
	output logic [can_rxbuf_pkg::HIT_W-1:0] o_hit,
	output logic o_ext_sel,
	output logic o_to_buf1
);
	// Quiet lines until the first frame
	initial begin
		{o_valid, o_error, o_ext, o_rtr, o_match, o_hit, o_ext_sel, o_to_buf1} = '0;
	end
	// One frame: a single-cycle pulse; fields are inverted after it so stale values cannot help the block
	task automatic send(input logic err, input logic ext, input logic rtr, input logic mt,
		input logic [can_rxbuf_pkg::HIT_W-1:0] hit, input logic sel, input logic b1);
		@(posedge i_mclk);
		o_valid <= 1'b1;
		{o_error, o_ext, o_rtr, o_match, o_hit, o_ext_sel, o_to_buf1} <= {err, ext, rtr, mt, hit, sel, b1};
		@(posedge i_mclk);
		o_valid <= 1'b0;
		{o_error, o_ext, o_rtr, o_match, o_hit, o_ext_sel, o_to_buf1} <= ~{err, ext, rtr, mt, hit, sel, b1};
	endtask
endmodule // can_node_model

// ==== bench/tb_can_rxbuf_ctrl.sv ====
// Self-checking bench for the dedicated receive buffer control block
`timescale 1ns/1ps
module tb_can_rxbuf_ctrl;
	logic i_mclk;
	logic i_rst_n;
	logic i_ce;
	logic [can_rxbuf_pkg::ADDR_W-1:0] adr;
	logic rd_en, wr_en;
	logic [can_rxbuf_pkg::DATA_W-1:0] wdat, rdat;
	logic [3:0] be;
	logic wait_req, vld, err_f, ext_f, rtr_f, mt_f, sel_f, b1_f;
	logic [can_rxbuf_pkg::HIT_W-1:0] hit_f, h5;
	logic full0, full1, lost, irq, r, acc;
	logic [1:0] m;
	logic [2:0] h3;
	logic [31:0] exp_q[$];
	int error_cnt;
	int checks_done;
	int k;

	// Clock at 20 MHz
	initial begin
		i_mclk = 1'b0;
		forever #25 i_mclk = ~i_mclk;
	end

	can_rxbuf_ctrl i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_avs_address(adr),
		.i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdat), .i_avs_byteenable(be),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wait_req), .i_msg_valid(vld), .i_msg_error(err_f),
		.i_msg_ext(ext_f), .i_msg_rtr(rtr_f), .i_filter_match(mt_f), .i_filter_hit(hit_f),
		.i_filter_ext_sel(sel_f), .i_enh_to_buf1(b1_f), .o_buf0_full(full0), .o_buf1_full(full1),
		.o_msg_lost(lost), .o_irq(irq));

	can_node_model u_node (.i_mclk(i_mclk), .o_valid(vld), .o_error(err_f), .o_ext(ext_f), .o_rtr(rtr_f),
		.o_match(mt_f), .o_hit(hit_f), .o_ext_sel(sel_f), .o_to_buf1(b1_f));

	////////////////////////////////////////////////////////////
	// Verdict and comparisons
	task automatic stop_test();
		if (error_cnt == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask

	task automatic flag(input logic exp, input logic got);
		chk({31'h0, exp}, {31'h0, got});
	endtask

	// Read data is taken at the edge where waitrequest is seen low; the oldest note is the expectation
	always @(posedge i_mclk) begin
		if (rd_en === 1'b1 && wait_req === 1'b0) begin
			chk(exp_q.size() > 0 ? exp_q.pop_front() : 32'hdead_beef, rdat);
		end
	end

	////////////////////////////////////////////////////////////
	// Bus master: holds the request until waitrequest is low, bounded wait
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [3:0] b);
		int n;
		logic late;
		n = 0;
		@(posedge i_mclk);
		{adr, rd_en, wr_en, wdat, be} <= {a, ~w, w, 24'h00_0000, d, b};
		do begin
			@(posedge i_mclk);
			n++;
		end while (wait_req !== 1'b0 && n < 20);
		late = (wait_req !== 1'b0);
		rd_en <= 1'b0;
		wr_en <= 1'b0;
		@(negedge i_mclk);
		// Bound used up without an answer counts as a mismatch
		if (late) begin
			error_cnt++;
			stop_test();
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'hf);
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 8'h00, 4'hf);
	endtask

	// A frame, then let its capture edge settle
	task automatic frame(input logic e, input logic x, input logic q, input logic mt, input logic [4:0] h,
		input logic s, input logic b1);
		u_node.send(e, x, q, mt, h, s, b1);
		@(negedge i_mclk);
	endtask

	////////////////////////////////////////////////////////////
	initial begin
		{i_rst_n, adr, rd_en, wr_en, wdat, be} = '0;
		i_ce = 1'b1;
		error_cnt = 0;
		checks_done = 0;
		void'($urandom(90));
		repeat (3) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		// Reset values, unmapped address included
		for (k = 0; k < 6; k++) rd(5'(k * 4), 32'h0);
		// Legacy accept-all, full handshake, drop and interrupt
		wr(can_rxbuf_pkg::OFS_BUF0, 8'h7b);
		rd(can_rxbuf_pkg::OFS_BUF0, 32'h60);
		frame(1'b1, 1'b0, 1'b1, 1'b0, 5'h00, 1'b0, 1'b0);
		flag(1'b1, full0);
		flag(1'b0, irq);
		wr(can_rxbuf_pkg::OFS_MASK, 8'h07);
		flag(1'b1, irq);
		rd(can_rxbuf_pkg::OFS_BUF0, 32'he8);
		frame(1'b0, 1'b0, 1'b0, 1'b0, 5'h00, 1'b0, 1'b0);
		flag(1'b1, lost);
		rd(can_rxbuf_pkg::OFS_BUF0, 32'he8);
		wr(can_rxbuf_pkg::OFS_STATUS, 8'h01);
		rd(can_rxbuf_pkg::OFS_STATUS, 32'h5);
		wr(can_rxbuf_pkg::OFS_BUF0, 8'he0);
		flag(1'b1, full0);
		wr(can_rxbuf_pkg::OFS_BUF0, 8'h60);
		flag(1'b0, full0);
		bus(1'b1, can_rxbuf_pkg::OFS_MASK, 8'h00, 4'he);
		wr(5'h14, 8'hff);
		rd(can_rxbuf_pkg::OFS_MASK, 32'h7);
		wr(can_rxbuf_pkg::OFS_STATUS, 8'h07);
		flag(1'b0, irq);
		// Every legacy filter mode on buffer 1 with every error and identifier kind
		for (k = 0; k < 16; k++) begin
			m = 2'(k >> 2);
			r = 1'($urandom);
			h3 = 3'($urandom_range(5, 2));
			acc = (m == 2'h3) || (!k[0] && (m == 2'h0 || (m == 2'h2 && k[1]) || (m == 2'h1 && !k[1])));
			wr(can_rxbuf_pkg::OFS_BUF1, {1'b0, m, 5'h00});
			frame(k[0], k[1], r, 1'b1, {2'b00, h3}, k[1], 1'b0);
			flag(acc, full1);
			if (acc) rd(can_rxbuf_pkg::OFS_BUF1, {24'h0, 1'b1, m, 1'b0, r, h3});
		end
		// Double buffering, jump offset copy and filter hit bit
		wr(can_rxbuf_pkg::OFS_BUF1, 8'h00);
		wr(can_rxbuf_pkg::OFS_BUF0, 8'h64);
		rd(can_rxbuf_pkg::OFS_BUF0, 32'h6e);
		frame(1'b0, 1'b0, 1'b0, 1'b1, 5'h01, 1'b0, 1'b0);
		rd(can_rxbuf_pkg::OFS_BUF0, 32'he7);
		frame(1'b0, 1'b1, 1'b1, 1'b1, 5'h00, 1'b1, 1'b0);
		flag(1'b1, full1);
		rd(can_rxbuf_pkg::OFS_BUF1, 32'h88);
		wr(can_rxbuf_pkg::OFS_BUF1, 8'h00);
		wr(can_rxbuf_pkg::OFS_BUF0, 8'he0);
		rd(can_rxbuf_pkg::OFS_BUF0, 32'he1);
		frame(1'b0, 1'b0, 1'b0, 1'b1, 5'h00, 1'b0, 1'b0);
		flag(1'b0, full1);
		flag(1'b1, lost);
		// Enhanced layouts, mode 3 counted as enhanced
		wr(can_rxbuf_pkg::OFS_MODE, 8'h01);
		rd(can_rxbuf_pkg::OFS_BUF0, 32'hc1);
		for (k = 1; k < 4; k++) begin
			h5 = 5'($urandom_range(15, 0));
			r = 1'($urandom);
			wr(can_rxbuf_pkg::OFS_MODE, 8'(k));
			wr(can_rxbuf_pkg::OFS_BUF0, 8'h40);
			frame(1'b1, 1'b0, r, 1'b1, h5, 1'b0, 1'b0);
			rd(can_rxbuf_pkg::OFS_BUF0, {24'h0, 2'b11, r, h5});
			wr(can_rxbuf_pkg::OFS_BUF1, 8'h00);
			frame(1'b0, 1'b1, 1'b1, 1'b0, 5'h03, 1'b1, 1'b1);
			flag(1'b0, full1);
			frame(1'b1, 1'b1, 1'b1, 1'b1, 5'h03, 1'b1, 1'b1);
			flag(1'b0, full1);
			frame(1'b0, 1'b1, r, 1'b1, h5, 1'b1, 1'b1);
			rd(can_rxbuf_pkg::OFS_BUF1, {24'h0, 2'b10, r, h5});
		end
		// Clock enable low freezes the block, so a frame then is not taken
		wr(can_rxbuf_pkg::OFS_BUF1, 8'h00);
		@(posedge i_mclk);
		i_ce <= 1'b0;
		frame(1'b0, 1'b1, 1'b0, 1'b1, 5'h02, 1'b1, 1'b1);
		flag(1'b0, full1);
		@(posedge i_mclk);
		i_ce <= 1'b1;
		frame(1'b0, 1'b1, 1'b0, 1'b1, 5'h02, 1'b1, 1'b1);
		flag(1'b1, full1);
		stop_test();
	end
endmodule // tb_can_rxbuf_ctrl
